// [shared/dpms_regs.vh]
`ifndef DPMS_REGS_VH
`define DPMS_REGS_VH
// Timing figures and derived cycle counts at 25 MHz (40 ns)
`define DPMS_CLK_NS          40
`define DPMS_LDO_UP_NS       100000
`define DPMS_LDO_UP_CYC      ((`DPMS_LDO_UP_NS) / `DPMS_CLK_NS)
`define DPMS_SWITCH_LDO_NS   2000000
`define DPMS_SWITCH_LDO_CYC  ((`DPMS_SWITCH_LDO_NS) / `DPMS_CLK_NS)
`define DPMS_SWITCH_DIR_NS   1000
`define DPMS_SWITCH_DIR_CYC  ((`DPMS_SWITCH_DIR_NS) / `DPMS_CLK_NS)
`define DPMS_RST_HOLD_NS     150
// Sample-period counts
`define DPMS_STEP_FS         8'h10
`define DPMS_START_FS        8'h04
`define DPMS_RST_FALL_FS     8'h03
`define DPMS_RST_RISE_FS     8'h02
`define DPMS_ZERO_RUN        14'h2000
// Reset values
`define DPMS_ATTEN_RST       8'hFF
`define DPMS_ATTEN_MUTE      8'h00
`endif

// [rtl/dpms_seq.v]
`timescale 1ns/1ps
`include "dpms_regs.vh"
// Operation
// - Mute ramps attenuation down, step per 16/fs
// - Unmute ramps back to programmed level
// - Early cancel reverses ramp at same rate
// - Zero flag after 8192 zeros, drops immediately
// - Regulator starts on release, 0.1ms allowed
// - Regulator fault locks out until power cycle
// - With regulator, switch closes within 2ms
// - Without regulator, switch closes within 1us
// - Power-down halts all, outputs high-impedance
// - Pin mode: analog at clocks, digital 4/fs
// - Register mode: accesses allowed once released
// - Register mode: divider 4/fs after clocks
// - Reset bit one enters normal operation
// - Internal reset lags bit 3-4 / 2-3 fs
// - Zero flags low while powered down
// - Stopped clocks in power-down are harmless
// - Reset bit clear resets core, flags high
module dpms_seq
(
    input  wire       mclk_i,              // Master clock, 25 MHz
    input  wire       nrst_i,              // Power-down pin, async, low
    input  wire       ce_i,                // Clock enable
    input  wire       regulator_enable_pin_i, // Regulator enable strap
    input  wire       control_style_select_i, // High pin mode, low reg
    input  wire       reg_fault_i,         // Regulator fault detect
    input  wire       clocks_present_i,    // Required audio clocks seen
    input  wire       frame_clock_i,       // Frame clock pin (fs)
    input  wire       soft_mute_req_pin_i, // Soft-mute pin
    input  wire       soft_mute_req_bit_i, // Soft-mute register bit
    input  wire       reset_release_bit_i, // Reset release bit
    input  wire [7:0] atten_level_value_i, // Programmed attenuation
    input  wire       zero_left_i,         // Left sample is zero
    input  wire       zero_right_i,        // Right sample is zero
    output reg        regulator_on_o,      // Regulator running
    output reg        core_switch_o,       // Core shutdown switch closed
    output reg        analog_on_o,         // Analog circuitry running
    output reg        divider_on_o,        // Clock divider running
    output reg        digital_on_o,        // Digital circuitry running
    output reg        reg_access_o,        // Register access allowed
    output reg        out_hiz_o,           // Analog outputs floating
    output reg        out_common_o,        // Outputs at common voltage
    output reg        fault_lock_o,        // Regulator error state
    output reg        int_reset_n_o,       // Internal core reset, low
    output reg  [7:0] atten_level_o,       // Current attenuation
    output reg        zero_flag_left_o,    // Left zero flag
    output reg        zero_flag_right_o    // Right zero flag
);

    // Power sequencer states
    localparam [2:0] ST_OFF   = 3'h0;      // Just released
    localparam [2:0] ST_LDO   = 3'h1;      // Regulator rising
    localparam [2:0] ST_SW    = 3'h2;      // Switch closing
    localparam [2:0] ST_CLK   = 3'h3;      // Waiting for clocks
    localparam [2:0] ST_WAIT  = 3'h4;      // Clocks seen, 4/fs
    localparam [2:0] ST_RUN   = 3'h5;      // Running
    localparam [2:0] ST_FAULT = 3'h6;      // Regulator lockout

    reg  [2:0]  st_q;                      // Sequencer state
    reg  [16:0] tmr_q;                     // Cycle timer
    reg  [7:0]  fs_cnt_q;                  // Sample period timer
    reg  [2:0]  fr_sync_q;                 // Frame clock synchroniser
    reg  [2:0]  ck_sync_q;                 // Clocks-present synchroniser
    reg  [2:0]  mp_sync_q;                 // Mute pin synchroniser
    reg  [2:0]  ft_sync_q;                 // Fault synchroniser
    reg         fr_prev_q;                 // Filtered frame clock
    reg         ldo_mode_q;                // Strap caught at release
    reg         rst_bit_q;                 // Last seen reset bit
    reg  [7:0]  rst_cnt_q;                 // Reset-latency counter
    reg  [7:0]  step_cnt_q;                // Mute step counter
    reg  [13:0] zl_cnt_q;                  // Left zero run
    reg  [13:0] zr_cnt_q;                  // Right zero run
    reg         strap_done_q;              // Strap captured

    // Filtered pin levels: second and third stages agree
    wire fr_lvl   = (fr_sync_q[1] == fr_sync_q[2]) ? fr_sync_q[2]
                                                   : fr_prev_q;
    wire fs_tick  = fr_lvl & ~fr_prev_q;   // Rising frame edge
    wire clk_ok   = ck_sync_q[1] & ck_sync_q[2];
    wire fault    = ft_sync_q[1] & ft_sync_q[2];
    wire mute_pin = mp_sync_q[1] & mp_sync_q[2];
    wire mute_req = mute_pin | soft_mute_req_bit_i;
    wire reg_mode = ~control_style_select_i;

    // Synchronisers for pins from outside the clock domain
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fr_sync_q <= 3'h0;
            ck_sync_q <= 3'h0;
            mp_sync_q <= 3'h0;
            ft_sync_q <= 3'h0;
            fr_prev_q <= 1'b0;
        end
        else if (ce_i)
        begin
            fr_sync_q <= {fr_sync_q[1:0], frame_clock_i};
            ck_sync_q <= {ck_sync_q[1:0], clocks_present_i};
            mp_sync_q <= {mp_sync_q[1:0], soft_mute_req_pin_i};
            ft_sync_q <= {ft_sync_q[1:0], reg_fault_i};
            fr_prev_q <= fr_lvl;
        end
    end

    // Power-up sequencer; power-down pin is the async reset
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            // All halted, outputs floating, flags low
            st_q           <= ST_OFF;
            tmr_q          <= 17'h0;
            fs_cnt_q       <= 8'h0;
            ldo_mode_q     <= 1'b0;
            strap_done_q   <= 1'b0;
            regulator_on_o <= 1'b0;
            core_switch_o  <= 1'b0;
            analog_on_o    <= 1'b0;
            divider_on_o   <= 1'b0;
            digital_on_o   <= 1'b0;
            reg_access_o   <= 1'b0;
            out_hiz_o      <= 1'b1;
            fault_lock_o   <= 1'b0;
        end
        else if (ce_i)
        begin
            case (st_q)
                ST_OFF:
                begin
                    // Catch the strap after release
                    ldo_mode_q   <= regulator_enable_pin_i;
                    strap_done_q <= 1'b1;
                    reg_access_o <= reg_mode;
                    tmr_q        <= 17'h0;
                    if (strap_done_q)
                    begin
                        if (ldo_mode_q)
                        begin
                            regulator_on_o <= 1'b1;
                            st_q           <= ST_LDO;
                        end
                        else
                        begin
                            core_switch_o <= 1'b1;
                            st_q          <= ST_CLK;
                        end
                    end
                end
                ST_LDO:
                begin
                    // Allow the regulator its rise time
                    tmr_q <= tmr_q + 17'h1;
                    if (tmr_q >= `DPMS_LDO_UP_CYC - 1)
                    begin
                        tmr_q <= 17'h0;
                        st_q  <= ST_SW;
                    end
                end
                ST_SW:
                begin
                    // Oscillator count before switch closes
                    tmr_q <= tmr_q + 17'h1;
                    if (tmr_q >= `DPMS_SWITCH_LDO_CYC -
                                 `DPMS_LDO_UP_CYC - 3)
                    begin
                        core_switch_o <= 1'b1;
                        st_q          <= ST_CLK;
                    end
                end
                ST_CLK:
                begin
                    // Wait for required audio clocks
                    if (clk_ok)
                    begin
                        analog_on_o <= 1'b1;
                        fs_cnt_q    <= 8'h0;
                        st_q        <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // Digital start and divider 4/fs later
                    if (fs_tick)
                        fs_cnt_q <= fs_cnt_q + 8'h1;
                    if (fs_tick && fs_cnt_q == `DPMS_START_FS - 8'h1)
                    begin
                        divider_on_o <= 1'b1;
                        digital_on_o <= 1'b1;
                        out_hiz_o    <= 1'b0;
                        st_q         <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    st_q <= ST_RUN;
                end
                ST_FAULT:
                begin
                    st_q <= ST_FAULT;
                end
                default:
                begin
                    st_q <= ST_OFF;
                end
            endcase
            // Regulator fault overrides everything until pin cycles
            if (ldo_mode_q && regulator_on_o && fault)
            begin
                st_q           <= ST_FAULT;
                regulator_on_o <= 1'b0;
                core_switch_o  <= 1'b0;
                analog_on_o    <= 1'b0;
                divider_on_o   <= 1'b0;
                digital_on_o   <= 1'b0;
                out_hiz_o      <= 1'b1;
                fault_lock_o   <= 1'b1;
            end
        end
    end

    // Internal reset follows the bit with 3 fall / 2 rise latency
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            int_reset_n_o <= 1'b0;
            rst_bit_q     <= 1'b0;
            rst_cnt_q     <= 8'h0;
        end
        else if (ce_i)
        begin
            if (!digital_on_o)
            begin
                int_reset_n_o <= 1'b0;
                rst_bit_q     <= 1'b0;
                rst_cnt_q     <= 8'h0;
            end
            else
            begin
                // In pin mode the core runs without the bit
                if ((reg_mode ? reset_release_bit_i : 1'b1) != rst_bit_q)
                begin
                    rst_bit_q <= ~rst_bit_q;
                    rst_cnt_q <= 8'h0;
                end
                else if (int_reset_n_o != rst_bit_q && fs_tick)
                begin
                    rst_cnt_q <= rst_cnt_q + 8'h1;
                    if (rst_cnt_q + 8'h1 >= (rst_bit_q ?
                        `DPMS_RST_RISE_FS : `DPMS_RST_FALL_FS))
                        int_reset_n_o <= rst_bit_q;
                end
            end
        end
    end

    // Common-voltage output while held in reset
    always @(*)
    begin
        out_common_o = ~out_hiz_o & ~int_reset_n_o;
    end

    // Soft-mute ramp, one step per 16/fs, reversible mid-ramp
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            atten_level_o <= `DPMS_ATTEN_MUTE;
            step_cnt_q    <= 8'h0;
        end
        else if (ce_i)
        begin
            if (!int_reset_n_o)
            begin
                atten_level_o <= atten_level_value_i;
                step_cnt_q    <= 8'h0;
            end
            else if (fs_tick)
            begin
                step_cnt_q <= step_cnt_q + 8'h1;
                if (step_cnt_q == `DPMS_STEP_FS - 8'h1)
                begin
                    step_cnt_q <= 8'h0;
                    if (mute_req && atten_level_o != `DPMS_ATTEN_MUTE)
                        atten_level_o <= atten_level_o - 8'h1;
                    else if (!mute_req &&
                             atten_level_o < atten_level_value_i)
                        atten_level_o <= atten_level_o + 8'h1;
                    else if (!mute_req)
                        atten_level_o <= atten_level_value_i;
                end
            end
        end
    end

    // Per-channel zero runs and flags
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            zl_cnt_q          <= 14'h0;
            zr_cnt_q          <= 14'h0;
            zero_flag_left_o  <= 1'b0;
            zero_flag_right_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!digital_on_o)
            begin
                zl_cnt_q          <= 14'h0;
                zr_cnt_q          <= 14'h0;
                zero_flag_left_o  <= 1'b0;
                zero_flag_right_o <= 1'b0;
            end
            else if (!rst_bit_q)
            begin
                zl_cnt_q          <= 14'h0;
                zr_cnt_q          <= 14'h0;
                zero_flag_left_o  <= 1'b1;
                zero_flag_right_o <= 1'b1;
            end
            else
            begin
                if (!zero_left_i)
                begin
                    zl_cnt_q         <= 14'h0;
                    zero_flag_left_o <= 1'b0;
                end
                else if (fs_tick)
                begin
                    if (zl_cnt_q != `DPMS_ZERO_RUN)
                        zl_cnt_q <= zl_cnt_q + 14'h1;
                    zero_flag_left_o <= (zl_cnt_q + 14'h1 >=
                                         `DPMS_ZERO_RUN);
                end
                if (!zero_right_i)
                begin
                    zr_cnt_q          <= 14'h0;
                    zero_flag_right_o <= 1'b0;
                end
                else if (fs_tick)
                begin
                    if (zr_cnt_q != `DPMS_ZERO_RUN)
                        zr_cnt_q <= zr_cnt_q + 14'h1;
                    zero_flag_right_o <= (zr_cnt_q + 14'h1 >=
                                          `DPMS_ZERO_RUN);
                end
            end
        end
    end

endmodule // dpms_seq

// [sim/dpms_host.sv]
`timescale 1ns/1ps
module dpms_host
(
    input  wire mclk_i,           // Master clock
    input  wire nrst_i,           // Power-down pin
    input  wire run_i,            // Audio clocks wanted
    output reg  frame_clock_o,    // Frame clock, fs = mclk/4
    output reg  clocks_present_o  // All audio clocks running
);
    reg [1:0] div_q; // Frame clock divider

    // Clocks stand low while stopped or powered down
    always @(posedge mclk_i)
    begin
        if (!run_i || !nrst_i)
        begin
            div_q <= 2'h0;
            frame_clock_o <= 1'b0;
            clocks_present_o <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            frame_clock_o <= div_q[1];
            clocks_present_o <= 1'b1;
        end
    end
endmodule // dpms_host

// [sim/dpms_seq_monitor.sv]
`timescale 1ns/1ps
module dpms_chk
(
    input wire       mclk_i,                 // Master clock
    input wire       nrst_i,                 // Power-down pin
    input wire       regulator_enable_pin_i, // Regulator strap
    input wire       control_style_select_i, // Pin or reg mode
    input wire       reset_release_bit_i,    // Reset bit
    input wire [7:0] atten_level_value_i,    // Programmed level
    input wire       zero_left_i,            // Left zero
    input wire       regulator_on_o,         // Regulator on
    input wire       core_switch_o,          // Switch closed
    input wire       analog_on_o,            // Analog on
    input wire       divider_on_o,           // Divider on
    input wire       digital_on_o,           // Digital on
    input wire       reg_access_o,           // Access allowed
    input wire       out_hiz_o,              // Outputs floating
    input wire       fault_lock_o,           // Fault state
    input wire       int_reset_n_o,          // Core reset
    input wire [7:0] atten_level_o,          // Attenuation
    input wire       zero_flag_left_o,       // Left flag
    input wire       zero_flag_right_o       // Right flag
);
    reg [15:0] wait_q; // Cycles since release with switch open

    // Counts the switch wait, saturating; frozen in regulator lockout
    always @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wait_q <= 16'h0000;
        else if (!core_switch_o && !fault_lock_o && wait_q != 16'hFFFF)
            wait_q <= wait_q + 16'h0001;
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_pd_outputs_safe: assert property (
        !$past(nrst_i) |-> out_hiz_o && !digital_on_o
            && !zero_flag_left_o && !zero_flag_right_o)
        else $error("outputs not safe at release");
    a_switch_bound: assert property (
        wait_q <= (regulator_enable_pin_i ? 16'hC350 : 16'h0019))
        else $error("switch closed late");
    a_reg_access: assert property (
        $rose(nrst_i) && !control_style_select_i |=> reg_access_o)
        else $error("access not allowed");
    a_regulator_start: assert property (
        $rose(nrst_i) && regulator_enable_pin_i |-> ##[1:4] regulator_on_o)
        else $error("regulator did not start");
    a_fault_hold: assert property (
        fault_lock_o |=> fault_lock_o && !regulator_on_o)
        else $error("fault state left");
    a_step_down: assert property (
        atten_level_o < $past(atten_level_o)
            && atten_level_o != atten_level_value_i
        |-> atten_level_o == $past(atten_level_o) - 8'h01)
        else $error("attenuation step wrong");
    a_step_spacing: assert property (
        $changed(atten_level_o) |=> $stable(atten_level_o)[*8])
        else $error("attenuation steps too fast");
    a_digital_order: assert property (
        $rose(digital_on_o) |-> analog_on_o && divider_on_o
            && !out_hiz_o && core_switch_o)
        else $error("digital started out of order");
    a_reset_lag: assert property (
        $rose(reset_release_bit_i) && !int_reset_n_o && digital_on_o
            && !control_style_select_i
        |-> (!int_reset_n_o)[*4] ##[1:30] int_reset_n_o)
        else $error("internal reset lag wrong");
    a_zero_drop: assert property (
        zero_flag_left_o && !zero_left_i && int_reset_n_o
            && reset_release_bit_i && $past(int_reset_n_o, 12)
        |=> !zero_flag_left_o)
        else $error("zero flag held");
    a_flags_on_reset: assert property (
        $fell(reset_release_bit_i) && digital_on_o && !control_style_select_i
        |-> ##[1:4] zero_flag_left_o && zero_flag_right_o)
        else $error("zero flags not raised");
endmodule // dpms_chk

bind dpms_seq dpms_chk dpms_chk_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i),
    .regulator_enable_pin_i(regulator_enable_pin_i),
    .control_style_select_i(control_style_select_i),
    .reset_release_bit_i(reset_release_bit_i),
    .atten_level_value_i(atten_level_value_i), .zero_left_i(zero_left_i),
    .regulator_on_o(regulator_on_o), .core_switch_o(core_switch_o),
    .analog_on_o(analog_on_o), .divider_on_o(divider_on_o),
    .digital_on_o(digital_on_o), .reg_access_o(reg_access_o),
    .out_hiz_o(out_hiz_o), .fault_lock_o(fault_lock_o),
    .int_reset_n_o(int_reset_n_o), .atten_level_o(atten_level_o),
    .zero_flag_left_o(zero_flag_left_o),
    .zero_flag_right_o(zero_flag_right_o));

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    reg         mclk_i, nrst_i, ce_i, ldo, pin_mode, fault, run; // Controls
    reg         mute_pin, mute_bit, rst_bit, zl, zr, zr_rand;   // Stimulus
    reg  [7:0]  value;                                          // Level
    reg  [31:0] rnd;                                            // Draw
    wire        fclk, present, reg_on, sw_on, an_on, div_on;    // Status
    wire        dig_on, acc, hiz, vcm, lock, irst_n, zfl, zfr;  // Status
    wire [7:0]  atten;                                          // Level
    integer     fail_count, total_checks, seed, k, t0, tgt, ticks, i, d;

    always #20 mclk_i = ~mclk_i;

    // Frame ticks seen at the pin
    always @(posedge fclk) ticks = ticks + 1;

    // Right channel zero level drawn at random
    always @(posedge mclk_i)
    begin
        rnd = $random(seed);
        zr <= zr_rand & rnd[0];
    end

    dpms_host dpms_host_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .run_i(run),
        .frame_clock_o(fclk), .clocks_present_o(present));

    dpms_seq dpms_seq_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .regulator_enable_pin_i(ldo), .control_style_select_i(pin_mode),
        .reg_fault_i(fault), .clocks_present_i(present),
        .frame_clock_i(fclk), .soft_mute_req_pin_i(mute_pin),
        .soft_mute_req_bit_i(mute_bit), .reset_release_bit_i(rst_bit),
        .atten_level_value_i(value), .zero_left_i(zl), .zero_right_i(zr),
        .regulator_on_o(reg_on), .core_switch_o(sw_on), .analog_on_o(an_on),
        .divider_on_o(div_on), .digital_on_o(dig_on), .reg_access_o(acc),
        .out_hiz_o(hiz), .out_common_o(vcm), .fault_lock_o(lock),
        .int_reset_n_o(irst_n), .atten_level_o(atten),
        .zero_flag_left_o(zfl), .zero_flag_right_o(zfr));

    // Counts and reports one comparison
    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp)
            begin
                fail_count = fail_count + 1;
                $display("Error %s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask

    // Ticks a ramp of n steps should take
    function integer exp_ticks(input integer n);
        exp_ticks = n * 16;
    endfunction

    // Selects a watched condition
    function logic sig(input integer s);
        case (s)
            0: sig = sw_on;
            1: sig = an_on;
            2: sig = dig_on;
            3: sig = irst_n;
            4: sig = zfl;
            default: sig = (atten === tgt[7:0]);
        endcase
    endfunction

    // Bounded wait for a condition to reach a level
    task wt(input integer s, input logic lvl, input integer lim);
        begin
            k = 0;
            while (sig(s) !== lvl && k < lim)
            begin
                @(negedge mclk_i);
                k = k + 1;
            end
        end
    endtask

    // Power-down pulse of n + 1 cycles with new straps
    task power_down_n_pin(input integer n, input logic l, input logic p);
        begin
            @(posedge mclk_i);
            nrst_i <= 1'b0;
            ldo <= l;
            pin_mode <= p;
            run <= 1'b0;
            repeat (n) @(posedge mclk_i);
            #1;
            check("pd_state", {hiz, dig_on, zfl, zfr}, 16'h8);
            @(posedge mclk_i);
            nrst_i <= 1'b1;
        end
    endtask

    // Waits for a ramp to reach a level and checks its duration
    task ramp(input integer to, input integer n);
        begin
            t0 = ticks;
            tgt = to;
            wt(5, 1'b1, n * 64 + 300);
            check("atten", atten, to[15:0]);
            d = ticks - t0 - exp_ticks(n);
            check("ramp_time", d <= 17 && d >= -17, 16'h1);
        end
    endtask

    task finish_test;
        begin
            $display("Checks %0d errors %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // Watchdog
    initial
    begin
        #4000000;
        fail_count = fail_count + 1;
        finish_test();
    end

    // Main sequence
    initial
    begin
        {mclk_i, nrst_i, ce_i, fault, run, mute_pin, mute_bit} = 7'h10;
        {rst_bit, zl, zr_rand, ldo, pin_mode} = 5'h00;
        {fail_count, total_checks, ticks, tgt} = 0;
        seed = 32'h8914;
        k = $random(seed);
        value = 8'h04 + {4'h0, k[3:0]};
        power_down_n_pin(11, 1'b1, 1'b0);
        wt(0, 1'b1, 60000);
        // k counts from the half cycle after release, so 2ms is k - 1
        check("switch_ldo", k <= 50001, 16'h1);
        check("reg_on_acc", {reg_on, acc}, 16'h3);
        @(posedge mclk_i);
        fault <= 1'b1;
        repeat (8) @(posedge mclk_i);
        fault <= 1'b0;
        repeat (20) @(negedge mclk_i);
        check("fault", {lock, reg_on}, 16'h2);
        power_down_n_pin(4, 1'b0, 1'b0);
        wt(0, 1'b1, 100);
        check("switch_direct", k <= 25, 16'h1);
        check("fault_clear", lock, 16'h0);
        run <= 1'b1;
        wt(1, 1'b1, 200);
        t0 = ticks;
        check("dig_early", dig_on, 16'h0);
        wt(2, 1'b1, 200);
        check("dig_ticks", ticks - t0 >= 3 && ticks - t0 <= 5, 16'h1);
        check("common", {vcm, irst_n}, 16'h2);
        @(posedge mclk_i);
        rst_bit <= 1'b1;
        t0 = ticks;
        wt(3, 1'b1, 100);
        check("rst_rise", ticks - t0 >= 2 && ticks - t0 <= 4, 16'h1);
        tgt = value;
        wt(5, 1'b1, 2000);
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge mclk_i);
            {mute_pin, mute_bit} <= (i == 0) ? 2'b10 : 2'b01;
            ramp(0, value);
            @(posedge mclk_i);
            {mute_pin, mute_bit} <= 2'b00;
            ramp(value, value);
        end
        @(posedge mclk_i);
        {mute_pin, mute_bit} <= 2'b11;
        ramp(value - 3, 3);
        @(posedge mclk_i);
        {mute_pin, mute_bit} <= 2'b00;
        ramp(value, 3);
        @(posedge mclk_i);
        zl <= 1'b1;
        zr_rand <= 1'b1;
        t0 = ticks;
        wt(4, 1'b1, 8192 * 4 + 400);
        check("zero_run", ticks - t0 >= 8191 && ticks - t0 <= 8196, 16'h1);
        check("zero_right", zfr, 16'h0);
        @(posedge mclk_i);
        zl <= 1'b0;
        zr_rand <= 1'b0;
        repeat (2) @(negedge mclk_i);
        check("zero_drop", zfl, 16'h0);
        @(posedge mclk_i);
        rst_bit <= 1'b0;
        t0 = ticks;
        wt(3, 1'b0, 100);
        check("rst_fall", ticks - t0 >= 3 && ticks - t0 <= 5, 16'h1);
        check("flags_rst", {zfl, zfr}, 16'h3);
        power_down_n_pin(4, 1'b0, 1'b1);
        run <= 1'b1;
        wt(2, 1'b1, 400);
        wt(3, 1'b1, 200);
        check("pin_mode_run", irst_n, 16'h1);
        finish_test();
    end
endmodule // testbench
